// ==== common/lcd_frame_regs.svh ====
// Register offsets, field positions, levels and timing constants of the frame driver.
`ifndef LCD_FRAME_REGS_SVH
`define LCD_FRAME_REGS_SVH
`define LCD_CTRL_ADDR    8'h00
`define LCD_PRE_ADDR     8'h04
`define LCD_SEGEN_ADDR   8'h08
`define LCD_IRQ_ADDR     8'h0c
`define LCD_PIX_PAGE     2'h1
`define LCD_PIX_BYTES    12
`define LCD_CTRL_EN      0
`define LCD_CTRL_WFT     1
`define LCD_CTRL_MUX     3:2
`define LCD_CTRL_CS      5:4
`define LCD_CTRL_HALT_IN_SLEEP_ENABLE   6
`define LCD_CTRL_WRITE_ERROR_FLAG    7
`define LCD_CTRL_ACTIVE  8
`define LCD_PRE_FIELD    3:0
`define LCD_IRQ_SHUT     0
`define LCD_IRQ_FRM      1
`define LCD_IRQ_SHUT_IE  2
`define LCD_IRQ_FRM_IE   3
`define LCD_SYSDIV_LAST  8'hff
`define LCD_HALF_UNIT    11'h010
`define LCD_K_STATIC     11'h004
`define LCD_K_HALF       11'h002
`define LCD_K_MORE       11'h001
`define LCD_V0           2'h0
`define LCD_V1           2'h1
`define LCD_V2           2'h2
`define LCD_V3           2'h3
`define LCD_NUM_COM      4
`endif

// ==== common/lcd_frame_pkg.sv ====
// Types shared by the frame driver modules.
package lcd_frame_pkg;
  typedef enum logic [1:0] {MUX_STATIC, MUX_HALF, MUX_THIRD, MUX_QUARTER} mux_t;
  typedef enum logic [1:0] {CS_SYSDIV, CS_SECOSC, CS_LFOSC, CS_LFOSC_ALT} clk_src_t;
endpackage : lcd_frame_pkg

// ==== logic/lcd_sync2.sv ====
// Two-flop synchroniser for levels that arrive from outside the core clock domain.
`timescale 1ns/10ps
module lcd_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_t;
  sync_t st;
  sync_t next_st;

  always_comb begin
    next_st.first  = d_in;
    next_st.second = st.first;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_out = st.second;
endmodule : lcd_sync2

// ==== logic/lcd_pixel_store.sv ====
// Pixel data bytes: one bit per pixel, plain read/write storage with a registered read port.
`timescale 1ns/10ps
module lcd_pixel_store #(
  parameter int BYTES = 12,
  parameter int AW    = 4
) (
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               wr_en_in,
  input  wire logic [AW-1:0]      addr_in,
  input  wire logic [7:0]         wdata_in,
  output logic      [7:0]         rdata_out,
  output logic      [8*BYTES-1:0] pixels_out
);
  typedef struct packed {
    logic [8*BYTES-1:0] mem;
    logic [7:0]         rdata;
  } store_t;
  store_t st;
  store_t next_st;

  // Unused bytes and bits are kept like any other, so software may use them freely.
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    if (int'(addr_in) < BYTES) begin
      next_st.rdata = st.mem[8*addr_in +: 8];
      if (wr_en_in) begin
        next_st.mem[8*addr_in +: 8] = wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out  = st.rdata;
  assign pixels_out = st.mem;
endmodule : lcd_pixel_store

// ==== logic/lcd_frame_driver.sv ====
// Segment display frame driver: APB registers, frame timing and common/segment pin drive.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "lcd_frame_regs.svh"
// Overview of operation
// - Multiplex select 00..11 drives one to four commons; unused commons stay plain I/O.
// - An active common ignores its pin direction bit.
// - A segment pin carries the segment waveform only when its enable bit is 1.
// - While the module is active, a set segment enable overrides the pin direction bit.
// - After reset all segment enables are clear and pins are plain I/O.
// - One stored bit per common/segment pixel selects dark or clear.
// - Common k uses bytes from 3k; segment n is bit n mod 8 of byte 3k+n/8.
// - Pixel bits not shown remain ordinary read/write storage.
// - Frame rate is source over k times (prescaler plus one) times 32 times commons.
// - Frame clock comes from core clock over 256, crystal or slow oscillator.
// - Pixels see no net DC; dark gets the higher RMS level.
// - Type-A flips phase within each common slot, Type-B at frame boundaries.
// - With the divided core clock, sleep halts the drive at once.
// - Going from active to inactive raises an interrupt.
// - Type-B raises a frame interrupt at every second frame boundary, after the odd frame.
// - Waveform type bit 0 selects Type-A, 1 selects Type-B.
// - No frame interrupt in Type-A nor in static Type-B.
// - Clearing enable stops only after the current frame, then clears active.
// - Blocked Type-B pixel writes are dropped and set the write error flag.
module lcd_frame_driver #(
  parameter int NUM_SEG = 16
) (
  input  wire logic                 CORE_CLK_IN,
  input  wire logic                 RST_N_IN,
  input  wire logic                 PSEL_IN,
  input  wire logic                 PENABLE_IN,
  input  wire logic                 PWRITE_IN,
  input  wire logic [7:0]           PADDR_IN,
  input  wire logic [31:0]          PWDATA_IN,
  input  wire logic                 SLEEP_IN,
  input  wire logic                 SEC_OSC_IN,
  input  wire logic                 LF_OSC_IN,
  input  wire logic [3:0]           COM_GPIO_DATA_IN,
  input  wire logic [3:0]           COM_PIN_DIR_IN,
  input  wire logic [NUM_SEG-1:0]   SEG_GPIO_DATA_IN,
  input  wire logic [NUM_SEG-1:0]   SEG_PIN_DIR_IN,
  output logic      [31:0]          PRDATA_OUT,
  output logic                      PREADY_OUT,
  output logic                      PSLVERR_OUT,
  output logic      [7:0]           COM_LEVEL_OUT,
  output logic      [3:0]           COM_OE_OUT,
  output logic      [2*NUM_SEG-1:0] SEG_LEVEL_OUT,
  output logic      [NUM_SEG-1:0]   SEG_OE_OUT,
  output logic                      IRQ_OUT
);
  import lcd_frame_pkg::*;

  typedef struct packed {
    logic                 en;
    logic                 waveform_type_bit;
    mux_t                 mux;
    clk_src_t             cs;
    logic                 halt_in_sleep_enable;
    logic                 write_error_flag;
    logic [3:0]           pre;
    logic [NUM_SEG-1:0]   segen;
    logic                 shut_flag;
    logic                 frm_flag;
    logic                 shut_ie;
    logic                 frm_ie;
    logic                 active;
    logic                 wft_act;
    mux_t                 mux_act;
    logic [7:0]           sysdiv;
    logic [1:0]           osc_prev;
    logic [10:0]          tick_cnt;
    logic [1:0]           slot;
    logic                 half;
    logic                 odd;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    logic [7:0]           com_lvl;
    logic [3:0]           com_oe;
    logic [2*NUM_SEG-1:0] seg_lvl;
    logic [NUM_SEG-1:0]   seg_oe;
    logic                 irq;
  } state_t;

  state_t                           st;
  state_t                           next_st;
  logic   [1:0]                     osc_sync;
  logic   [7:0]                     pix_rdata;
  logic   [8*`LCD_PIX_BYTES-1:0]    pix_flat;
  logic                             access;
  logic                             wr;
  logic                             pix_hit;
  logic                             mapped;
  logic                             halted;
  logic                             blank;
  logic                             src_tick;
  logic                             last_tick;
  logic                             boundary;
  logic                             blocked;
  logic                             phase;
  logic   [31:0]                    rd;

  function automatic logic is_pix(input logic [7:0] a);
    return a[7:6] == `LCD_PIX_PAGE && int'(a[5:2]) < `LCD_PIX_BYTES && a[1:0] == '0;
  endfunction : is_pix

  // Half of one common slot, in source ticks, minus one.
  function automatic logic [10:0] half_last(input mux_t m, input logic [3:0] p);
    logic [10:0] k;
    unique case (m)
      MUX_STATIC: k = `LCD_K_STATIC;
      MUX_HALF:   k = `LCD_K_HALF;
      MUX_THIRD:  k = `LCD_K_MORE;
      MUX_QUARTER: k = `LCD_K_MORE;
    endcase
    return k * `LCD_HALF_UNIT * (11'(p) + 11'h001) - 11'h001;
  endfunction : half_last

  function automatic logic pix_at(input logic [8*`LCD_PIX_BYTES-1:0] f,
                                  input logic [1:0] c, input int n);
    return f[8 * (3 * int'(c) + n / 8) + n % 8];
  endfunction : pix_at

  function automatic logic [1:0] com_level(input logic stat, input logic sel,
                                           input logic ph);
    if (stat) return ph ? `LCD_V3 : `LCD_V0;
    if (sel) return ph ? `LCD_V0 : `LCD_V3;
    return ph ? `LCD_V2 : `LCD_V1;
  endfunction : com_level

  // Dark pixels swing opposite to the selected common, clear ones stay near it.
  function automatic logic [1:0] seg_level(input logic stat, input logic dark,
                                           input logic ph);
    if (stat) return (dark ^ ph) ? `LCD_V3 : `LCD_V0;
    if (dark) return ph ? `LCD_V3 : `LCD_V0;
    return ph ? `LCD_V1 : `LCD_V2;
  endfunction : seg_level

  lcd_sync2 #(.W(2)) u_osc_sync (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     ({LF_OSC_IN, SEC_OSC_IN}),
    .q_out    (osc_sync)
  );

  lcd_pixel_store #(.BYTES(`LCD_PIX_BYTES), .AW(4)) u_pixels (
    .clk_in     (CORE_CLK_IN),
    .rst_n_in   (RST_N_IN),
    .wr_en_in   (wr && pix_hit && !blocked),
    .addr_in    (PADDR_IN[5:2]),
    .wdata_in   (PWDATA_IN[7:0]),
    .rdata_out  (pix_rdata),
    .pixels_out (pix_flat)
  );

  assign access  = PSEL_IN && PENABLE_IN;
  assign wr      = access && st.pready && PWRITE_IN;
  assign pix_hit = is_pix(PADDR_IN);
  assign mapped  = pix_hit || PADDR_IN == `LCD_CTRL_ADDR || PADDR_IN == `LCD_PRE_ADDR
                   || PADDR_IN == `LCD_SEGEN_ADDR || PADDR_IN == `LCD_IRQ_ADDR;
  assign halted  = SLEEP_IN && (st.halt_in_sleep_enable || st.cs == CS_SYSDIV);
  assign blank   = halted && st.halt_in_sleep_enable;
  // Type-B multiplexed data may change only in the first slot after a complete pair.
  assign blocked = st.active && st.wft_act && st.mux_act != MUX_STATIC
                   && !(!st.odd && st.slot == '0);
  assign src_tick = (st.cs == CS_SYSDIV) ? st.sysdiv == `LCD_SYSDIV_LAST :
                    (st.cs == CS_SECOSC) ? osc_sync[0] && !st.osc_prev[0] :
                    osc_sync[1] && !st.osc_prev[1];
  assign last_tick = src_tick && st.tick_cnt == half_last(st.mux_act, st.pre);
  assign boundary  = st.active && !halted && last_tick && st.half && st.slot == st.mux_act;
  assign phase     = st.wft_act ? st.odd : st.half;

  always_comb begin
    next_st = st;
    rd = '0;
    next_st.sysdiv   = st.sysdiv + 8'h01;
    next_st.osc_prev = osc_sync;

    if (pix_hit) begin
      rd[7:0] = pix_rdata;
    end else if (PADDR_IN == `LCD_CTRL_ADDR) begin
      rd[`LCD_CTRL_EN]     = st.en;
      rd[`LCD_CTRL_WFT]    = st.waveform_type_bit;
      rd[`LCD_CTRL_MUX]    = st.mux;
      rd[`LCD_CTRL_CS]     = st.cs;
      rd[`LCD_CTRL_HALT_IN_SLEEP_ENABLE]  = st.halt_in_sleep_enable;
      rd[`LCD_CTRL_WRITE_ERROR_FLAG]   = st.write_error_flag;
      rd[`LCD_CTRL_ACTIVE] = st.active;
    end else if (PADDR_IN == `LCD_PRE_ADDR) begin
      rd[`LCD_PRE_FIELD] = st.pre;
    end else if (PADDR_IN == `LCD_SEGEN_ADDR) begin
      rd[NUM_SEG-1:0] = st.segen;
    end else if (PADDR_IN == `LCD_IRQ_ADDR) begin
      rd[`LCD_IRQ_SHUT]    = st.shut_flag;
      rd[`LCD_IRQ_FRM]     = st.frm_flag;
      rd[`LCD_IRQ_SHUT_IE] = st.shut_ie;
      rd[`LCD_IRQ_FRM_IE]  = st.frm_ie;
    end

    next_st.pready = access && !st.pready;
    if (access && !st.pready) begin
      next_st.pslverr = !mapped;
      next_st.prdata  = rd;
    end

    if (wr && PADDR_IN == `LCD_CTRL_ADDR) begin
      next_st.en    = PWDATA_IN[`LCD_CTRL_EN];
      next_st.waveform_type_bit   = PWDATA_IN[`LCD_CTRL_WFT];
      next_st.mux   = mux_t'(PWDATA_IN[`LCD_CTRL_MUX]);
      next_st.cs    = clk_src_t'(PWDATA_IN[`LCD_CTRL_CS]);
      next_st.halt_in_sleep_enable = PWDATA_IN[`LCD_CTRL_HALT_IN_SLEEP_ENABLE];
      if (PWDATA_IN[`LCD_CTRL_WRITE_ERROR_FLAG]) next_st.write_error_flag = 1'b0;
    end
    if (wr && PADDR_IN == `LCD_PRE_ADDR) next_st.pre = PWDATA_IN[`LCD_PRE_FIELD];
    if (wr && PADDR_IN == `LCD_SEGEN_ADDR) next_st.segen = PWDATA_IN[NUM_SEG-1:0];
    if (wr && PADDR_IN == `LCD_IRQ_ADDR) begin
      if (PWDATA_IN[`LCD_IRQ_SHUT]) next_st.shut_flag = 1'b0;
      if (PWDATA_IN[`LCD_IRQ_FRM]) next_st.frm_flag = 1'b0;
      next_st.shut_ie = PWDATA_IN[`LCD_IRQ_SHUT_IE];
      next_st.frm_ie  = PWDATA_IN[`LCD_IRQ_FRM_IE];
    end
    if (wr && pix_hit && blocked) next_st.write_error_flag = 1'b1;

    if (st.en && !st.active) begin
      next_st.active   = 1'b1;
      next_st.mux_act  = st.mux;
      next_st.wft_act  = st.waveform_type_bit;
      next_st.tick_cnt = '0;
      next_st.slot     = '0;
      next_st.half     = 1'b0;
      next_st.odd      = 1'b0;
    end else if (st.active && !halted && src_tick) begin
      if (last_tick) begin
        next_st.tick_cnt = '0;
        next_st.half     = !st.half;
        if (st.half && st.slot == st.mux_act) begin
          next_st.slot    = '0;
          next_st.odd     = !st.odd;
          next_st.mux_act = st.mux;
          next_st.wft_act = st.waveform_type_bit;
          if (!st.en) begin
            next_st.active    = 1'b0;
            next_st.shut_flag = 1'b1;
          end
          // Only the end of a full even/odd pair is reported.
          if (st.wft_act && st.mux_act != MUX_STATIC && st.odd) begin
            next_st.frm_flag = 1'b1;
          end
        end else if (st.half) begin
          next_st.slot = st.slot + 2'h1;
        end
      end else begin
        next_st.tick_cnt = st.tick_cnt + 11'h001;
      end
    end

    next_st.irq = (st.shut_flag && st.shut_ie) || (st.frm_flag && st.frm_ie);

    // While halted in sleep the pins keep the last pattern, or sit at V0 when halt_in_sleep_enable is set.
    for (int c = 0; c < `LCD_NUM_COM; c++) begin
      if (st.active && 2'(c) <= st.mux_act) begin
        next_st.com_oe[c] = 1'b1;
        next_st.com_lvl[2*c +: 2] = blank ? `LCD_V0 :
          com_level(st.mux_act == MUX_STATIC, 2'(c) == st.slot, phase);
      end else begin
        next_st.com_oe[c] = !COM_PIN_DIR_IN[c];
        next_st.com_lvl[2*c +: 2] = COM_GPIO_DATA_IN[c] ? `LCD_V3 : `LCD_V0;
      end
    end
    for (int n = 0; n < NUM_SEG; n++) begin
      if (st.active && st.segen[n]) begin
        next_st.seg_oe[n] = 1'b1;
        next_st.seg_lvl[2*n +: 2] = blank ? `LCD_V0 :
          seg_level(st.mux_act == MUX_STATIC, pix_at(pix_flat, st.slot, n), phase);
      end else begin
        next_st.seg_oe[n] = !SEG_PIN_DIR_IN[n];
        next_st.seg_lvl[2*n +: 2] = SEG_GPIO_DATA_IN[n] ? `LCD_V3 : `LCD_V0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA_OUT    = st.prdata;
  assign PREADY_OUT    = st.pready;
  assign PSLVERR_OUT   = st.pslverr;
  assign COM_LEVEL_OUT = st.com_lvl;
  assign COM_OE_OUT    = st.com_oe;
  assign SEG_LEVEL_OUT = st.seg_lvl;
  assign SEG_OE_OUT    = st.seg_oe;
  assign IRQ_OUT       = st.irq;

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_quarter_coms: assert property (
    (st.active && st.mux_act == MUX_QUARTER) |=> COM_OE_OUT == 4'hf)
    else $error("quarter multiplex does not drive all commons");
  a_static_idle: assert property (
    (st.active && st.mux_act == MUX_STATIC && COM_PIN_DIR_IN[3]) |=> !COM_OE_OUT[3])
    else $error("unused common driven in static mode");
  a_seg_override: assert property (
    (st.active && st.segen[0]) |=> SEG_OE_OUT[0])
    else $error("enabled segment pin not driven");
  a_seg_gpio: assert property (
    (!st.segen[0]) |=> SEG_OE_OUT[0] == !$past(SEG_PIN_DIR_IN[0]))
    else $error("disabled segment pin left its I/O function");
  a_reset_plain: assert property (disable iff (1'b0)
    !RST_N_IN |=> st.segen == '0 && !st.active)
    else $error("segment enables not clear in reset");
  a_no_frame_typea: assert property (
    (!st.frm_flag && !st.wft_act && !wr) |=> !st.frm_flag)
    else $error("frame interrupt raised in Type-A");
  a_shut_flag: assert property (
    $fell(st.active) |-> st.shut_flag)
    else $error("shutdown did not raise the flag");
  a_stop_frame_end: assert property (
    (st.active && !boundary) |=> st.active)
    else $error("module stopped before frame end");
  a_halt_freeze: assert property (
    (st.active && halted && !(st.en && !st.active)) |=> $stable(st.tick_cnt) && $stable(st.slot))
    else $error("frame timing ran while halted");
  a_write_error_flag_block: assert property (
    (wr && pix_hit && blocked) |=> st.write_error_flag && $stable(pix_flat))
    else $error("blocked pixel write not flagged");
  a_irq_gate: assert property (
    (!st.shut_ie && !st.frm_ie) |=> !IRQ_OUT)
    else $error("interrupt output without enable");
  a_cfg_hold: assert property (
    (st.active && !boundary) |=> $stable(st.mux_act) && $stable(st.wft_act))
    else $error("multiplex changed inside a frame");

  c_shutdown: cover property ($fell(st.active));
  c_frame_irq: cover property ($rose(st.frm_flag));
  c_write_error: cover property ($rose(st.write_error_flag));
  c_halted: cover property (st.active && halted);
endmodule : lcd_frame_driver

// ==== tb/lcd_glass_model.sv ====
// Passive glass model: net voltage and drive energy seen by one pixel.
`timescale 1ns/10ps
module lcd_glass_model (
  input  wire logic       clk_in,
  input  wire logic       clr_in,
  input  wire logic [1:0] com_level_in,
  input  wire logic       com_oe_in,
  input  wire logic [1:0] seg_level_in,
  input  wire logic       seg_oe_in,
  output int              dc_out,
  output int              sq_out
);
  int diff;
  assign diff = int'(com_level_in) - int'(seg_level_in);
  // A floating electrode leaves the pixel undefined, so it adds nothing to either sum.
  always @(posedge clk_in) begin
    if (clr_in) begin
      dc_out <= 0;
      sq_out <= 0;
    end else if (com_oe_in && seg_oe_in) begin
      dc_out <= dc_out + diff;
      sq_out <= sq_out + diff * diff;
    end
  end
endmodule : lcd_glass_model

// ==== tb/tb_lcd_frame_driver.sv ====
// Self-checking bench for the frame driver: registers, pin drive, timing and events.
`timescale 1ns/10ps
`include "lcd_frame_regs.svh"
module tb_lcd_frame_driver;
  import lcd_frame_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, sleep, sec_osc, lf_osc, pready, pslverr;
  logic        irq, err, clr;
  logic [7:0]  paddr, com_lv;
  logic [31:0] pwdata, prdata, rd, seg_lv, snap;
  logic [3:0]  com_oe, com_dir;
  logic [3:0]  div = 4'h0;
  logic [15:0] seg_oe, seg_dir, gpio;
  int          miscompares, num_checks, dc, sq, n;

  lcd_frame_driver dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .SLEEP_IN(sleep), .SEC_OSC_IN(sec_osc), .LF_OSC_IN(lf_osc), .COM_GPIO_DATA_IN(gpio[3:0]),
    .COM_PIN_DIR_IN(com_dir), .SEG_GPIO_DATA_IN(gpio), .SEG_PIN_DIR_IN(seg_dir),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .COM_LEVEL_OUT(com_lv), .COM_OE_OUT(com_oe), .SEG_LEVEL_OUT(seg_lv),
    .SEG_OE_OUT(seg_oe), .IRQ_OUT(irq));
  lcd_glass_model glass (.clk_in(clk), .clr_in(clr), .com_level_in(com_lv[1:0]),
    .com_oe_in(com_oe[0]), .seg_level_in(seg_lv[17:16]), .seg_oe_in(seg_oe[8]),
    .dc_out(dc), .sq_out(sq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Oscillator pins toggle every 4 and 8 core cycles, so one tick is 8 or 16 cycles.
  always @(posedge clk) begin
    div <= div + 4'h1;
    sec_osc <= div[2];
    lf_osc <= div[3];
  end

  task automatic test_done;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  task automatic fail(input string m);
    miscompares++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      fail("bus answer missing");
      test_done();
    end
    // One idle edge, so the next call never reassigns psel in this time step.
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask : rdc
  // Counts edges until common 0 changes level, or until the bound runs out.
  task automatic wchg(input int lim);
    logic [1:0] o;
    o = com_lv[1:0];
    n = 0;
    while (com_lv[1:0] === o && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      fail("level change missing");
      test_done();
    end
  endtask : wchg
  task automatic wirq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      fail("interrupt missing");
      test_done();
    end
  endtask : wirq
  task automatic tend(input string m);
    $display("test done: %s", m);
  endtask : tend

  initial begin
    #500000;
    fail("watchdog");
    test_done();
  end

  initial begin
    {rst_n, psel, penable, pwrite, sleep, clr} = 6'h00;
    {paddr, pwdata} = 40'h0;
    gpio = 16'h0002;
    com_dir = 4'b1011;
    seg_dir = 16'hff00;
    miscompares = 0;
    num_checks = 0;
    cyc(16);
    rst_n <= 1'b1;
    cyc(2);
    chk(com_oe, 4'h4, "com plain io");
    chk(seg_oe, 16'h00ff, "seg plain io");
    chk(seg_lv[3:2], 2'h3, "seg plain data high");
    chk(seg_lv[1:0], 2'h0, "seg plain data low");
    rdc(`LCD_CTRL_ADDR, 32'h0, "ctrl reset");
    rdc(`LCD_SEGEN_ADDR, 32'h0, "segen reset");
    rdc(`LCD_IRQ_ADDR, 32'h0, "irq reset");
    apb(1'b0, 8'h30, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    wr(8'h48, 32'hffff_ffa5);
    rdc(8'h48, 32'ha5, "spare pixel byte");
    wr(8'h6c, 32'h3c);
    rdc(8'h6c, 32'h3c, "last pixel byte");
    wr(8'h44, 32'h01);
    tend("reset and storage");
    // Segments 0 and 8 enabled; segment 8 is dark on common 0, segment 0 clear.
    wr(`LCD_SEGEN_ADDR, 32'h0101);
    wr(`LCD_CTRL_ADDR, 32'h11);
    cyc(8);
    chk(com_oe, 4'h5, "static commons");
    chk(seg_oe, 16'h01ff, "segment override");
    wchg(3000);
    wchg(600);
    chk(n, 512, "static half period");
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    chk(seg_lv[17:16], 2'h3 - com_lv[1:0], "dark segment 8");
    chk(seg_lv[1:0], com_lv[1:0], "clear segment 0");
    cyc(1025);
    chk(dc, 0, "net dc one frame");
    chk(sq, 9216, "dark drive energy");
    tend("static drive");
    for (int m = 0; m < 4; m++) begin
      wr(`LCD_CTRL_ADDR, 32'h11 | (m << 2));
      cyc(2100);
      chk(com_oe, ((1 << (m + 1)) - 1) | 4'h4, "mux commons");
    end
    wr(`LCD_PRE_ADDR, 32'h1);
    wr(`LCD_CTRL_ADDR, 32'h2d);
    wchg(2000);
    wchg(2000);
    wchg(2000);
    chk(n, 512, "slow source prescaled half");
    wr(`LCD_PRE_ADDR, 32'h0);
    tend("multiplex and timing");
    wr(`LCD_IRQ_ADDR, 32'hb);
    wr(`LCD_CTRL_ADDR, 32'h1f);
    wirq(5000);
    rdc(`LCD_IRQ_ADDR, 32'ha, "frame flag");
    cyc(400);
    wr(8'h40, 32'h55);
    rdc(`LCD_CTRL_ADDR, 32'h19f, "write error set");
    rdc(8'h40, 32'h0, "blocked write dropped");
    wr(`LCD_CTRL_ADDR, 32'h9f);
    rdc(`LCD_CTRL_ADDR, 32'h11f, "write error cleared");
    wr(`LCD_IRQ_ADDR, 32'ha);
    cyc(3);
    chk(irq, 1'b0, "frame irq cleared");
    tend("type b events");
    for (int j = 0; j < 2; j++) begin
      wr(`LCD_CTRL_ADDR, j ? 32'h13 : 32'h1d);
      cyc(1100);
      wr(`LCD_IRQ_ADDR, 32'ha);
      cyc(4500);
      rdc(`LCD_IRQ_ADDR, 32'h8, "no frame flag");
      chk(irq, 1'b0, "no frame irq");
    end
    tend("no frame events");
    wr(`LCD_IRQ_ADDR, 32'h7);
    wr(`LCD_CTRL_ADDR, 32'h10);
    rdc(`LCD_CTRL_ADDR, 32'h110, "active until frame end");
    wirq(3000);
    rdc(`LCD_CTRL_ADDR, 32'h10, "inactive");
    rdc(`LCD_IRQ_ADDR, 32'h5, "shutdown flag");
    wr(`LCD_IRQ_ADDR, 32'h1);
    tend("shutdown");
    wr(`LCD_CTRL_ADDR, 32'h0d);
    cyc(200);
    sleep <= 1'b1;
    cyc(2);
    snap = seg_lv;
    n = com_lv;
    cyc(9000);
    chk(com_lv, n, "core source frozen commons");
    chk(seg_lv, snap, "core source frozen segments");
    sleep <= 1'b0;
    wr(`LCD_CTRL_ADDR, 32'h1d);
    sleep <= 1'b1;
    wchg(600);
    wr(`LCD_CTRL_ADDR, 32'h5d);
    cyc(3);
    chk(com_lv, 8'h00, "sleep blank commons");
    chk(seg_lv[17:16], 2'h0, "sleep blank segment");
    sleep <= 1'b0;
    tend("sleep");
    test_done();
  end
endmodule : tb_lcd_frame_driver
